//--- logic/ude_pkg.sv
// Register map, field layout and timing constants for the endpoint event block
package ude_pkg;
	localparam int NUM_EP = 8;
	localparam int CNT_W = 11;
	localparam int TMR_W = 18;
	localparam int ADR_W = 8;

	// Clock rate and event times
	localparam int CLK_KHZ = 50000;
	localparam int SUSPEND_TIME_US = 3000;
	localparam int RESUME_TIME_US = 2000;
	localparam int SUSPEND_CYCLES = SUSPEND_TIME_US * CLK_KHZ / 1000;
	localparam int RESUME_CYCLES = RESUME_TIME_US * CLK_KHZ / 1000;

	// Byte offsets
	localparam logic [ADR_W-1:0] OFS_UNMASK = 8'h00;
	localparam logic [ADR_W-1:0] OFS_BLOCK = 8'h04;
	localparam logic [ADR_W-1:0] OFS_MASK = 8'h08;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_CLEAR = 8'h10;
	localparam logic [ADR_W-1:0] OFS_FIFO_RST = 8'h14;
	localparam logic [ADR_W-1:0] OFS_CONTROL = 8'h18;
	localparam logic [ADR_W-1:0] OFS_CSR_BASE = 8'h20;
	localparam logic [ADR_W-1:0] OFS_CSR_LAST = 8'h3C;

	// Global event bit positions in status, clear and mask
	localparam int BIT_SUSPEND = 8;
	localparam int BIT_BUS_RESUME = 9;
	localparam int BIT_LOCAL_RESUME = 10;
	localparam int BIT_FRAME_START = 11;
	localparam int BIT_RESET_DONE = 12;
	localparam int BIT_HOST_WAKE = 13;
	localparam int EVT_LO = 8;
	localparam int EVT_HI = 13;
	localparam int EVT_W = EVT_HI - EVT_LO + 1;

	// Interrupt mask layout and reset value; bus resume starts enabled
	localparam int MASK_W = 14;
	localparam logic [MASK_W-1:0] MASK_WRITABLE = 14'h2FFF;
	localparam logic [MASK_W-1:0] MASK_RESET = 14'h0200;
	localparam logic [MASK_W-1:0] MASK_ALWAYS_ON = 14'h1000;

	// Control register bits
	localparam int BIT_REMOTE_WAKE = 0;
	localparam int BIT_SUSPENDED = 1;

	// Endpoint control/status fields
	localparam int BIT_IN_DONE = 0;
	localparam int BIT_BANK0 = 1;
	localparam int BIT_SETUP = 2;
	localparam int BIT_STALL_ACK = 3;
	localparam int BIT_BANK1 = 6;
	localparam int BIT_TOGGLE = 11;
	localparam int CNT_LO = 16;
	localparam int CNT_HI = 26;

	typedef enum logic [1:0] {
		UDE_ACTIVE = 2'b00,
		UDE_SUSPENDED = 2'b01,
		UDE_RESUMING = 2'b11
	} ude_link_t;
endpackage

//--- logic/ude_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
module ude_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Level
	input wire logic async_i,
	output logic sync_o
);
	typedef struct packed {
		logic meta;
		logic sync;
	} ude_sync_state_t;

	ude_sync_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (ce_i) begin
			s_d.meta = async_i;
			s_d.sync = s_q.meta;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_o = s_q.sync;
endmodule

//--- logic/ude_top.sv
// Interrupt, status and endpoint control logic of the USB device port
// Summary of operation
// RQ1: Endpoint status bit is one while any of its flags is one.
// RQ2: Endpoint status bit stays until firmware clears the causing endpoint flag.
// RQ3: No bus activity for 3 ms sets suspend flag and enters suspend.
// RQ4: Host resume signalling on the port sets the bus-resume flag.
// RQ5: Rising edge of local resume request while suspended sets local-resume flag.
// RQ6: With remote wake enabled, a local resume request drives resume onto the bus.
// RQ7: Every detected frame-start token sets the frame-start flag.
// RQ8: End of bus reset sets reset-done flag; endpoint 0 then accepts requests.
// RQ9: Host resume or reset since last clear sets the host-wake flag.
// RQ10: Writing 1 to clear bits 8 to 13 clears that event; 0 does nothing.
// RQ11: While endpoint reset bit is 1, pointers and count are 0, toggle DATA0.
// RQ12: Firmware writes the endpoint reset bit back to 0 when done.
// RQ13: Endpoint reset leaves the endpoint control/status flags untouched.
// RQ14: Host ack of IN data sets bit 0; write 0 clears, write 1 ignored.
// RQ15: Firmware waits for the IN done flag before assuming acknowledgement.
// RQ16: Packet stored in bank 0 sets bit 1; write 0 clears, write 1 ignored.
// RQ17: Firmware reads the byte count, then clears bank 0 flag to release it.
// RQ18: Byte count is read-only at bits 26 down to 16 of each endpoint register.
// RQ19: Unmask writes set mask bits, block writes clear; only masked-in events interrupt. Code lets reset-done interrupt whatever the mask.
// RQ20: Bus-resume mask bit resets to enabled.
// RQ21: Event flags stay set until cleared; a same-cycle set wins over clear.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
module ude_top
	import ude_pkg::*;
#(
	parameter int SUSPEND_CNT = SUSPEND_CYCLES,
	parameter int RESUME_CNT = RESUME_CYCLES
) (
	// Clock, reset, clock enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial engine events, one-cycle pulses on clk_i, and the byte count taken with a bank 0 store
	input wire logic bus_activity_i,
	input wire logic host_resume_i,
	input wire logic frame_start_i,
	input wire logic bus_reset_seen_i,
	input wire logic bus_reset_end_i,
	input wire logic [NUM_EP-1:0] in_done_set_i,
	input wire logic [NUM_EP-1:0] bank0_store_i,
	input wire logic [NUM_EP-1:0] toggle_flip_i,
	input wire logic [CNT_W-1:0] rx_len_i,
	// Serial engine flag levels owned elsewhere
	input wire logic [NUM_EP-1:0] setup_received_i,
	input wire logic [NUM_EP-1:0] bank1_received_i,
	input wire logic [NUM_EP-1:0] stall_acknowledged_i,
	// Local resume request pin, asynchronous
	input wire logic resume_request_i,
	// Outputs
	output logic irq_o,
	output logic suspended_o,
	output logic resume_drive_o,
	output logic [NUM_EP-1:0] fifo_reset_o,
	output logic [NUM_EP-1:0] packet_toggle_o,
	output logic [NUM_EP-1:0] bank0_busy_o
);
	// All state of the block except the resume pin synchroniser, registered as one word
	typedef struct packed {
		logic [31:0] dat;
		logic ack;
		logic irq;
		ude_link_t link;
		logic [TMR_W-1:0] tmr;
		logic [EVT_W-1:0] evt;
		logic [MASK_W-1:0] mask;
		logic remote_wake;
		logic [NUM_EP-1:0] fifo_rst;
		logic [NUM_EP-1:0] in_done;
		logic [NUM_EP-1:0] bank0;
		logic [NUM_EP-1:0] toggle;
		logic [NUM_EP-1:0][CNT_W-1:0] count;
		logic req_prev;
		logic susp;
		logic drive;
	} ude_state_t;

	ude_state_t s_q, s_d;
	logic req_sync;
	logic [NUM_EP-1:0] ep_event;

	// True for the eight endpoint control/status words
	function automatic logic is_csr(input logic [ADR_W-1:0] a);
		return (a >= OFS_CSR_BASE) && (a <= OFS_CSR_LAST);
	endfunction

	// Endpoint number of a control/status word
	function automatic logic [2:0] csr_ep(input logic [ADR_W-1:0] a);
		logic [ADR_W-1:0] d;
		d = a - OFS_CSR_BASE;
		return d[4:2];
	endfunction

	// Byte lanes of the mask; lane 1 carries the global event bits
	localparam logic [MASK_W-1:0] LANE_LO = MASK_W'((1 << EVT_LO) - 1);
	localparam logic [MASK_W-1:0] LANE_HI = ~LANE_LO;

	// Mask after an unmask or block write to one lane; reset-done is never writable
	function automatic logic [MASK_W-1:0] mask_lane(input logic [MASK_W-1:0] old,
		input logic [31:0] dat, input logic [MASK_W-1:0] lane, input logic set);
		logic [MASK_W-1:0] hit;
		hit = dat[MASK_W-1:0] & MASK_WRITABLE & lane;
		if (set) begin
			return old | hit;
		end
		return old & ~hit;
	endfunction

	// Local resume pin crosses into the clock domain here
	ude_sync u_resume_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i(resume_request_i),
		.sync_o(req_sync)
	);

	// Endpoint status follows its flags, so it clears only through them
	generate
		for (genvar e = 0; e < NUM_EP; e++) begin : g_ep_event
			logic own_flags;
			logic far_flags;
			assign own_flags = s_q.in_done[e] | s_q.bank0[e];
			assign far_flags = setup_received_i[e] | bank1_received_i[e] | stall_acknowledged_i[e];
			assign ep_event[e] = own_flags | far_flags; // RQ1 RQ2
		end
	endgenerate

	always_comb begin
		logic access;
		logic wr;
		logic [2:0] ep;
		logic [EVT_W-1:0] evt_set;
		logic [EVT_W-1:0] evt_clr;
		logic [MASK_W-1:0] status;
		logic local_edge;
		access = 1'b0;
		wr = 1'b0;
		ep = 3'h0;
		evt_set = '0;
		evt_clr = '0;
		status = '0;
		local_edge = 1'b0;
		s_d = s_q;
		if (ce_i) begin
			access = wb_cyc_i && wb_stb_i && !s_q.ack;
			wr = access && wb_we_i;
			ep = csr_ep(wb_adr_i);
			// Ack blocks a retake, so one access takes two cycles
			s_d.ack = access;
			s_d.req_prev = req_sync;
			// Pin idles low and the history resets low: no false edge after reset
			local_edge = req_sync && !s_q.req_prev;

			// Link activity watchdog and resume driving
			case (s_q.link)
				UDE_ACTIVE: begin
					if (bus_activity_i) begin
						s_d.tmr = '0;
					end else if (s_q.tmr == TMR_W'(SUSPEND_CNT - 1)) begin
						s_d.tmr = '0;
						s_d.link = UDE_SUSPENDED; // RQ3
						evt_set[BIT_SUSPEND-EVT_LO] = 1'b1; // RQ3
					end else begin
						s_d.tmr = s_q.tmr + TMR_W'(1);
					end
				end
				UDE_SUSPENDED: begin
					if (local_edge) begin
						evt_set[BIT_LOCAL_RESUME-EVT_LO] = 1'b1; // RQ5
						if (s_q.remote_wake) begin
							s_d.link = UDE_RESUMING; // RQ6
						end
					end
					// Any bus activity means the host woke the link itself
					if (bus_activity_i || host_resume_i || bus_reset_seen_i) begin
						s_d.link = UDE_ACTIVE;
					end
				end
				// Resume is driven for a fixed time, then the link is active
				UDE_RESUMING: begin
					if (s_q.tmr == TMR_W'(RESUME_CNT - 1)) begin
						s_d.tmr = '0;
						s_d.link = UDE_ACTIVE;
					end else begin
						s_d.tmr = s_q.tmr + TMR_W'(1);
					end
				end
				default: begin
					s_d.link = UDE_ACTIVE;
					s_d.tmr = '0;
				end
			endcase

			if (host_resume_i) begin
				evt_set[BIT_BUS_RESUME-EVT_LO] = 1'b1; // RQ4
			end
			if (host_resume_i || bus_reset_seen_i) begin
				evt_set[BIT_HOST_WAKE-EVT_LO] = 1'b1; // RQ9
			end
			if (frame_start_i) begin
				evt_set[BIT_FRAME_START-EVT_LO] = 1'b1; // RQ7
			end
			if (bus_reset_end_i) begin
				evt_set[BIT_RESET_DONE-EVT_LO] = 1'b1; // RQ8
			end

			// Register writes
			if (wr && wb_sel_i[1]) begin
				case (wb_adr_i)
					OFS_UNMASK: begin
						s_d.mask = mask_lane(s_d.mask, wb_dat_i, LANE_HI, 1'b1); // RQ19
					end
					OFS_BLOCK: begin
						s_d.mask = mask_lane(s_d.mask, wb_dat_i, LANE_HI, 1'b0); // RQ19
					end
					OFS_CLEAR: begin
						evt_clr = wb_dat_i[EVT_HI:EVT_LO]; // RQ10
					end
					default: begin
					end
				endcase
			end
			if (wr && wb_sel_i[0]) begin
				case (wb_adr_i)
					OFS_UNMASK: begin
						s_d.mask = mask_lane(s_d.mask, wb_dat_i, LANE_LO, 1'b1); // RQ19
					end
					OFS_BLOCK: begin
						s_d.mask = mask_lane(s_d.mask, wb_dat_i, LANE_LO, 1'b0); // RQ19
					end
					OFS_FIFO_RST: begin
						s_d.fifo_rst = wb_dat_i[NUM_EP-1:0]; // RQ12
					end
					OFS_CONTROL: begin
						s_d.remote_wake = wb_dat_i[BIT_REMOTE_WAKE];
					end
					default: begin
						if (is_csr(wb_adr_i)) begin
							if (!wb_dat_i[BIT_IN_DONE]) begin
								s_d.in_done[ep] = 1'b0; // RQ14
							end
							if (!wb_dat_i[BIT_BANK0]) begin
								s_d.bank0[ep] = 1'b0; // RQ16 RQ17
							end
						end
					end
				endcase
			end

			// Set wins over a same-cycle clear
			s_d.evt = (s_q.evt & ~evt_clr) | evt_set; // RQ21 RQ10

			// Hardware sets come after firmware clears, so a same-cycle set wins
			for (int e = 0; e < NUM_EP; e++) begin
				if (in_done_set_i[e]) begin
					s_d.in_done[e] = 1'b1; // RQ14
				end
				if (bank0_store_i[e]) begin
					s_d.bank0[e] = 1'b1; // RQ16
					s_d.count[e] = rx_len_i;
				end
				if (toggle_flip_i[e]) begin
					s_d.toggle[e] = ~s_q.toggle[e];
				end
				// Flags are left alone here on purpose
				if (s_q.fifo_rst[e]) begin
					s_d.count[e] = '0; // RQ11 RQ13
					s_d.toggle[e] = 1'b0; // RQ11
				end
			end

			// Pin copies of the link state, registered so they never glitch
			s_d.susp = (s_d.link == UDE_SUSPENDED);
			s_d.drive = (s_d.link == UDE_RESUMING); // RQ6

			// Interrupt line from masked status
			status = {s_q.evt, ep_event};
			s_d.irq = |(status & (s_q.mask | MASK_ALWAYS_ON)); // RQ19

			// Read data
			s_d.dat = '0;
			// Unmapped addresses still ack and read as zero
			if (access && !wb_we_i) begin
				case (wb_adr_i)
					OFS_MASK: begin
						s_d.dat[MASK_W-1:0] = s_q.mask & MASK_WRITABLE;
					end
					OFS_STATUS: begin
						s_d.dat[MASK_W-1:0] = status; // RQ1
					end
					OFS_FIFO_RST: begin
						s_d.dat[NUM_EP-1:0] = s_q.fifo_rst;
					end
					OFS_CONTROL: begin
						s_d.dat[BIT_REMOTE_WAKE] = s_q.remote_wake;
						s_d.dat[BIT_SUSPENDED] = (s_q.link != UDE_ACTIVE);
					end
					default: begin
						if (is_csr(wb_adr_i)) begin
							s_d.dat[BIT_IN_DONE] = s_q.in_done[ep];
							s_d.dat[BIT_BANK0] = s_q.bank0[ep];
							s_d.dat[BIT_SETUP] = setup_received_i[ep];
							s_d.dat[BIT_STALL_ACK] = stall_acknowledged_i[ep];
							s_d.dat[BIT_BANK1] = bank1_received_i[ep];
							s_d.dat[BIT_TOGGLE] = s_q.toggle[ep];
							s_d.dat[CNT_HI:CNT_LO] = s_q.fifo_rst[ep] ? '0 : s_q.count[ep]; // RQ18 RQ11
						end
					end
				endcase
			end
		end
	end

	// Reset leaves the link active with only bus resume enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.link <= UDE_ACTIVE;
			s_q.mask <= MASK_RESET; // RQ20
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.dat;
	assign wb_ack_o = s_q.ack;
	assign irq_o = s_q.irq;
	assign suspended_o = s_q.susp;
	assign resume_drive_o = s_q.drive; // RQ6
	assign fifo_reset_o = s_q.fifo_rst; // RQ11
	assign packet_toggle_o = s_q.toggle;
	assign bank0_busy_o = s_q.bank0;
endmodule

//--- testbench/ude_checker.sv
// Port assertions for the endpoint event block
`timescale 1ns/10ps
module ude_checker
	import ude_pkg::*;
#(
	parameter int SUSPEND_CNT = SUSPEND_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Events
	input wire logic bus_activity_i,
	input wire logic host_resume_i,
	input wire logic bus_reset_end_i,
	input wire logic [NUM_EP-1:0] bank0_store_i,
	// Outputs
	input wire logic irq_o,
	input wire logic suspended_o,
	input wire logic resume_drive_o,
	input wire logic [NUM_EP-1:0] fifo_reset_o,
	input wire logic [NUM_EP-1:0] packet_toggle_o,
	input wire logic [NUM_EP-1:0] bank0_busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Idle cycles since bus activity; while ce_i stays high the design's timer never runs ahead of it outside resume driving
	logic [31:0] idle_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || bus_activity_i)
			idle_q <= '0;
		else
			idle_q <= idle_q + 32'h1;
	end
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	chk_reset_irq: assert property (bus_reset_end_i |-> ##2 irq_o)
		else $error("reset done did not interrupt");
	chk_toggle_data0: assert property
		(($past(fifo_reset_o) & fifo_reset_o & packet_toggle_o) == '0)
		else $error("toggle not zero in endpoint reset");
	chk_bank0_set: assert property
		(|bank0_store_i |=> (bank0_busy_o & $past(bank0_store_i)) == $past(bank0_store_i))
		else $error("bank0 flag not set");
	chk_suspend_idle: assert property ($rose(suspended_o) |-> idle_q >= 32'(SUSPEND_CNT - 2))
		else $error("suspend too early");
	chk_activity_wakes: assert property (suspended_o && bus_activity_i |-> ##[1:3] !suspended_o)
		else $error("activity did not end suspend");
	chk_host_wakes: assert property (suspended_o && host_resume_i |-> ##[1:3] !suspended_o)
		else $error("host resume did not end suspend");
	chk_resume_hold: assert property ($rose(resume_drive_o) |-> resume_drive_o[*8])
		else $error("resume drive too short");
endmodule

//--- testbench/ude_host_model.sv
// Host side model: bench commands become serial engine pulses
`timescale 1ns/10ps
module ude_host_model
	import ude_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Command: 1 resume, 2 frame, 3 reset, 4 reset end, 5 activity, 6 in ack, 7 store, 8 flip
	input wire logic [3:0] op_i,
	input wire logic [2:0] ep_i,
	input wire logic [CNT_W-1:0] len_i,
	// Pulses
	output logic [4:0] ev_o,
	output logic [NUM_EP-1:0] done_o,
	output logic [NUM_EP-1:0] bank0_o,
	output logic [NUM_EP-1:0] flip_o,
	output logic [CNT_W-1:0] len_o
);
	logic [NUM_EP-1:0] one;
	assign one = NUM_EP'(1) << ep_i;
	initial {ev_o, done_o, bank0_o, flip_o, len_o} = '0;
	always @(posedge clk_i) begin
		ev_o <= 5'h0;
		if (op_i inside {[4'h1:4'h5]})
			ev_o[op_i - 4'h1] <= 1'b1;
		done_o <= (op_i == 4'h6) ? one : '0;
		bank0_o <= (op_i == 4'h7) ? one : '0;
		flip_o <= (op_i == 4'h8) ? one : '0;
		// Count only valid with a store, scrambled otherwise
		len_o <= (op_i == 4'h7) ? len_i : ~len_o;
	end
endmodule

//--- testbench/usb_device_endpoint_events_test.sv
// Self-checking bench for the endpoint event block
`timescale 1ns/10ps
module usb_device_endpoint_events_test;
	import ude_pkg::*;
	localparam int SUSP = 20;
	localparam logic [7:0] c3 = OFS_CSR_BASE + 8'h0C;
	localparam logic [7:0] c5 = OFS_CSR_BASE + 8'h14;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b0, ce = 1'b1, ack, irq, susp, drive;
	logic [7:0] adr = '0;
	logic [31:0] wd = '0, rd;
	logic [3:0] op = '0;
	logic [2:0] ep = '0;
	logic [CNT_W-1:0] len = '0, rxlen;
	logic [4:0] ev;
	logic [NUM_EP-1:0] done, bk0, flip, frst, tgl, busy, setup = '0, bk1 = '0, stall = '0;
	int err_total = 0, total_checks = 0;
	ude_top #(.SUSPEND_CNT(SUSP), .RESUME_CNT(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .bus_activity_i(ev[4]),
		.host_resume_i(ev[0]), .frame_start_i(ev[1]), .bus_reset_seen_i(ev[2]),
		.bus_reset_end_i(ev[3]), .in_done_set_i(done), .bank0_store_i(bk0), .toggle_flip_i(flip),
		.rx_len_i(rxlen), .setup_received_i(setup), .bank1_received_i(bk1),
		.stall_acknowledged_i(stall), .resume_request_i(pin), .irq_o(irq), .suspended_o(susp),
		.resume_drive_o(drive), .fifo_reset_o(frst), .packet_toggle_o(tgl), .bank0_busy_o(busy));
	ude_host_model i_host (.clk_i(clk_i), .op_i(op), .ep_i(ep), .len_i(len), .ev_o(ev),
		.done_o(done), .bank0_o(bk0), .flip_o(flip), .len_o(rxlen));
	initial forever #10 clk_i = ~clk_i;
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask
	// Held until ack is sampled, then one idle cycle
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rd;
		if (n >= 40)
			chk("ack", 32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] q;
		bus(a, 1'b0, '0, q);
		chk(s, q & m, e);
	endtask
	task automatic host(input logic [3:0] c, input logic [2:0] e, input logic [CNT_W-1:0] l);
		op <= c;
		ep <= e;
		len <= l;
		@(posedge clk_i);
		op <= 4'h0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic t_regs();
		rdc("mask", OFS_MASK, 32'h2FFF, 32'h0200);
		wr(OFS_UNMASK, 32'hFFFFFFFF);
		rdc("mask", OFS_MASK, 32'h2FFF, 32'h2FFF);
		wr(OFS_BLOCK, 32'hFFFFFFFF);
		rdc("mask", OFS_MASK, 32'h2FFF, 32'h0);
		rdc("hole", 8'hFC, 32'hFFFFFFFF, 32'h0);
		$display("regs done");
	endtask
	task automatic t_events();
		logic [31:0] ev_bits [4] = '{32'h2200, 32'h0800, 32'h2000, 32'h1000};
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CLEAR, 32'h3F00);
			host(4'(i + 1), 3'h0, '0);
			rdc("event", OFS_STATUS, 32'h3E00, ev_bits[i]);
			wr(OFS_CLEAR, 32'h0);
			rdc("clr0", OFS_STATUS, 32'h3E00, ev_bits[i]);
			wr(OFS_CLEAR, ev_bits[i]);
			rdc("clr1", OFS_STATUS, 32'h3E00, 32'h0);
		end
		wr(OFS_UNMASK, 32'h0800);
		host(4'h2, 3'h0, '0);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(OFS_BLOCK, 32'h0800);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(OFS_CLEAR, 32'h3F00);
		ce <= 1'b0;
		host(4'h2, 3'h0, '0);
		ce <= 1'b1;
		rdc("freeze", OFS_STATUS, 32'h0800, 32'h0);
		$display("events done");
	endtask
	task automatic t_endpoint();
		host(4'h6, 3'h3, '0);
		rdc("in", c3, 32'h3, 32'h1);
		rdc("ep", OFS_STATUS, 32'hFF, 32'h08);
		wr(c3, 32'h1);
		rdc("in", c3, 32'h1, 32'h1);
		wr(c3, 32'h0);
		rdc("ep", OFS_STATUS, 32'hFF, 32'h0);
		host(4'h7, 3'h5, 11'h40);
		chk("busy", {24'h0, busy}, 32'h20);
		wr(c5, 32'h07FF0002);
		rdc("cnt", c5, 32'h07FF0003, 32'h00400002);
		host(4'h8, 3'h5, '0);
		chk("tgl", {24'h0, tgl}, 32'h20);
		wr(OFS_FIFO_RST, 32'h20);
		rdc("frst", OFS_FIFO_RST, 32'hFF, 32'h20);
		chk("frst", {24'h0, frst}, 32'h20);
		rdc("cnt", c5, 32'h07FF0003, 32'h00000002);
		chk("tgl", {24'h0, tgl}, 32'h0);
		wr(OFS_FIFO_RST, 32'h0);
		wr(c5, 32'h0);
		rdc("bk0", c5, 32'h3, 32'h0);
		setup <= 8'h80;
		stall <= 8'h02;
		bk1 <= 8'h04;
		@(posedge clk_i);
		rdc("lvl", OFS_STATUS, 32'hFF, 32'h86);
		$display("endpoint done");
	endtask
	task automatic t_suspend();
		int n;
		host(4'h5, 3'h0, '0);
		wr(OFS_CLEAR, 32'h3F00);
		chk("susp", {31'h0, susp}, 32'h0);
		repeat (SUSP + 4) @(posedge clk_i);
		chk("susp", {31'h0, susp}, 32'h1);
		rdc("susp", OFS_STATUS, 32'h0100, 32'h0100);
		host(4'h1, 3'h0, '0);
		chk("wake", {31'h0, susp}, 32'h0);
		rdc("rsm", OFS_STATUS, 32'h2200, 32'h2200);
		repeat (SUSP + 4) @(posedge clk_i);
		pin <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("drive", {31'h0, drive}, 32'h0);
		rdc("ext", OFS_STATUS, 32'h0400, 32'h0400);
		wr(OFS_CLEAR, 32'h0400);
		pin <= 1'b0;
		wr(OFS_CONTROL, 32'h1);
		repeat (SUSP + 4) @(posedge clk_i);
		pin <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("drive", {31'h0, drive}, 32'h1);
		n = 0;
		while (drive === 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		chk("drive", {31'h0, drive}, 32'h0);
		rdc("ext", OFS_STATUS, 32'h0400, 32'h0400);
		pin <= 1'b0;
		repeat (SUSP + 4) @(posedge clk_i);
		host(4'h5, 3'h0, '0);
		chk("wake", {31'h0, susp}, 32'h0);
		$display("suspend done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_events();
		t_endpoint();
		t_suspend();
		wrap_up();
	end
	initial begin
		repeat (4000) @(posedge clk_i);
		err_total++;
		wrap_up();
	end
endmodule
bind ude_top ude_checker #(.SUSPEND_CNT(SUSPEND_CNT)) i_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .bus_activity_i, .host_resume_i, .bus_reset_end_i, .bank0_store_i,
	.irq_o, .suspended_o, .resume_drive_o, .fifo_reset_o, .packet_toggle_o, .bank0_busy_o);
